/* design/hiob_pkg.sv */
// Constants and carrier types for the host I/O base and map decoder
package hiob_pkg;
    localparam int CLK_PERIOD_NS       = 10;
    localparam int RESET_MIN_NS        = 400;
    localparam int RESET_MIN_CYC       =
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] CFG_A_RST   = 8'h39;
    localparam logic [7:0] CFG_B_RST   = 8'h00;
    localparam logic [7:0] CFG_C_RST   = 8'h00;
    // Register offsets inside the 32-byte window
    localparam logic [4:0] OFS_HCMD    = 5'h00;
    localparam logic [4:0] OFS_SLOT    = 5'h01;
    localparam logic [4:0] OFS_HCFG    = 5'h02;
    localparam logic [4:0] OFS_CFGA    = 5'h03;
    localparam logic [4:0] OFS_CTL2    = 5'h05;
    localparam logic [4:0] OFS_STATION_ADDRESS_WINDOW    = 5'h08;
    localparam logic [4:0] OFS_CORE    = 5'h10;
    localparam logic [4:0] OFS_DPORT   = 5'h10;
    localparam logic [4:0] OFS_RSTPORT = 5'h18;
    // Field positions
    localparam int HCMD_ENABLE_BIT     = 0;
    localparam int HCFG_BANK_BIT       = 0;
    localparam int HCFG_EXT_BIT        = 1;
    localparam int CFGB_IOPORT_BIT     = 0;
    localparam int CFGB_NONCOMPAT_BIT  = 1;
    localparam int CFGC_SIZE_LSB       = 0;
    localparam int STATION_ADDRESS_WINDOW_BYTES          = 16;
    // Fixed top address bits for small SRAMs
    localparam logic [1:0] SMALL_TOP   = 2'b01;

    typedef enum logic [1:0] {
        HIOB_RAM_8K, HIOB_RAM_16K, HIOB_RAM_32K, HIOB_RAM_64K
    } hiob_ram_size_t;

    typedef enum logic [1:0] {
        HIOB_IDLE, HIOB_IO, HIOB_MEM, HIOB_DMA
    } hiob_cycle_t;

    typedef struct packed {
        logic [9:0]  io_addr;
        logic        io_rd_n;
        logic        io_wr_n;
        logic        mem_sel;
        logic [15:0] mem_addr;
        logic        mem_rd_n;
        logic        mem_wr_n;
        logic        word;
        logic [15:0] wdata;
    } hiob_host_t;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
    } hiob_cfg_t;
endpackage : hiob_pkg

/* design/hiob_top.sv */
// Host I/O base decode, register window and buffer address mapping
`timescale 1ns/1ps
module hiob_top
    import hiob_pkg::*;
#(
    parameter int RST_MIN = RESET_MIN_CYC
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                reset,
    // Straps
    input  wire hiob_pkg::hiob_cfg_t cfg_pins,
    input  wire logic                slot_width_input,
    // Host bus
    input  wire hiob_pkg::hiob_host_t host,
    output logic [15:0]              host_rdata,
    output logic                     host_rdata_oe,
    // Network core register port
    input  wire logic [7:0]          core_rdata,
    output logic                     network_core_sel,
    output logic                     network_core_wr,
    output logic [3:0]               network_core_reg,
    output logic [7:0]               network_core_wdata,
    // Remote DMA from the core
    input  wire logic                rdma_active,
    input  wire logic [15:0]         rdma_addr,
    output logic                     rdma_step,
    // Station address load and store
    input  wire logic                station_address_window_load_we,
    input  wire logic [3:0]          station_address_window_load_addr,
    input  wire logic [7:0]          station_address_window_load_data,
    input  wire logic [3:0]          station_address_window_store_addr,
    output logic [7:0]               station_address_window_store_data,
    // Buffer SRAM
    input  wire logic [15:0]         buf_rdata,
    output logic [15:1]              buffer_address,
    output logic                     ram_chip_select_one_n,
    output logic                     ram_chip_select_two_n,
    output logic                     buf_rd_n,
    output logic                     buf_wr_n,
    output logic [15:0]              buf_wdata,
    output logic                     buf_wdata_oe,
    // Status and control to the rest of the chip
    output logic [9:0]               io_base,
    output logic                     io_base_valid,
    output logic [7:0]               host_control_first,
    output logic [7:0]               host_control_second,
    output logic                     slot_width_status
);
    import hiob_pkg::*;

    // Base lookup shared by decode and status
    function automatic logic [10:0] base_of(input logic [2:0] sel,
                                            input logic       bank);
        logic [10:0] r;
        r = 11'h000;
        unique case ({bank, sel})
            4'h0: r = {1'b1, 10'h300};
            4'h1: r = {1'b0, 10'h000};
            4'h2: r = {1'b1, 10'h240};
            4'h3: r = {1'b1, 10'h280};
            4'h4: r = {1'b1, 10'h2c0};
            4'h5: r = {1'b1, 10'h320};
            4'h6: r = {1'b1, 10'h340};
            4'h7: r = {1'b1, 10'h360};
            4'h8: r = {1'b1, 10'h380};
            4'h9: r = {1'b1, 10'h3a0};
            4'ha: r = {1'b1, 10'h3c0};
            4'hb: r = {1'b1, 10'h3e0};
            4'hc: r = {1'b1, 10'h200};
            4'hd: r = {1'b1, 10'h220};
            4'he: r = {1'b1, 10'h2a0};
            4'hf: r = {1'b1, 10'h2e0};
        endcase
        return r;
    endfunction : base_of

    // Configuration and hidden registers
    logic [7:0]  cfg_a_ff;
    logic [7:0]  cfg_b_ff;
    logic [7:0]  cfg_c_ff;
    logic [7:0]  hcmd_ff;
    logic [7:0]  hcfg_ff;
    logic [7:0]  ctl1_ff;
    logic [7:0]  ctl2_ff;
    logic        slot_ff;
    logic [7:0]  station_address_window_mem [STATION_ADDRESS_WINDOW_BYTES];
    logic [7:0]  station_address_window_store_ff;
    // Reset length tracking
    logic [6:0]  rst_cnt_ff;
    logic        rst_prev_ff;
    logic        rst_long_ff;
    // Registered outputs
    logic [15:0] rdata_ff;
    logic        rdata_oe_ff;
    logic        core_sel_ff;
    logic        core_wr_ff;
    logic [3:0]  core_reg_ff;
    logic [7:0]  core_wdata_ff;
    logic        step_ff;
    logic [15:1] baddr_ff;
    logic        cs1_n_ff;
    logic        cs2_n_ff;
    logic        brd_n_ff;
    logic        bwr_n_ff;
    logic [15:0] bwdata_ff;
    logic        bwoe_ff;
    logic [9:0]  base_ff;
    logic        base_ok_ff;
    hiob_cycle_t cyc_ff;
    hiob_cycle_t nxt_cyc;

    // Base decode
    wire         hid_en   = hcmd_ff[HCMD_ENABLE_BIT];
    wire         ext_en   = hcfg_ff[HCFG_EXT_BIT];
    wire         bank_use = hid_en & ext_en & hcfg_ff[HCFG_BANK_BIT];
    wire [10:0]  base_raw = base_of(cfg_a_ff[2:0], bank_use);
    wire         base_ok  = base_raw[10];
    wire [9:0]   base     = base_raw[9:0];

    // Mode straps
    wire         io_mode   = cfg_b_ff[CFGB_IOPORT_BIT];
    wire         noncompat = cfg_b_ff[CFGB_NONCOMPAT_BIT];
    wire [1:0]   size_code = cfg_c_ff[CFGC_SIZE_LSB +: 2];
    hiob_ram_size_t ram_size;
    assign ram_size = hiob_ram_size_t'(size_code);

    // Window hit
    wire         io_hit  = base_ok
                         & (host.io_addr[9:5] == base[9:5]);
    wire [4:0]   ofs     = host.io_addr[4:0];
    wire         io_rd   = io_hit & ~host.io_rd_n;
    wire         io_wr   = io_hit & ~host.io_wr_n;
    wire         io_any  = io_rd | io_wr;

    // Window region decode
    wire         in_station_address_window = ~io_mode & (ofs[4:3] == OFS_STATION_ADDRESS_WINDOW[4:3]);
    wire         in_core = io_mode ? ~ofs[4]
                                   : (ofs[4] == OFS_CORE[4]);
    wire         in_port = io_mode
                         & (ofs[4:3] == OFS_DPORT[4:3]);
    wire         port_go = in_port & rdma_active;

    // Host memory access
    wire         mem_rd  = ~io_mode & host.mem_sel & ~host.mem_rd_n;
    wire         mem_wr  = ~io_mode & host.mem_sel & ~host.mem_wr_n;
    wire [15:0]  mem_ofs = noncompat ? host.mem_addr
                         : {2'b00, host.mem_addr[13:0]};

    // Remote DMA STATION_ADDRESS_WINDOW image
    wire         dma_station_address_window = noncompat ? (rdma_addr[15:8] == 8'h00)
                                      : ~rdma_addr[14];
    wire [7:0]   dma_pbyte = station_address_window_mem[rdma_addr[4:1]];

    // Buffer byte address and transfer width
    wire         use_mem  = mem_rd | mem_wr;
    wire [15:0]  ba       = use_mem ? mem_ofs : rdma_addr;
    wire         is_word  = use_mem ? host.word : 1'b1;
    wire         buf_rd   = mem_rd | (io_rd & port_go & ~dma_station_address_window);
    wire         buf_wr   = mem_wr | (io_wr & port_go);
    wire         buf_go   = buf_rd | buf_wr;

    // Top address bits and chip selects
    logic [2:0]  top3;
    logic        cs1;
    logic        cs2;
    always_comb begin
        top3 = {SMALL_TOP, ba[0]};
        cs1  = 1'b1;
        cs2  = 1'b0;
        unique case (ram_size)
            HIOB_RAM_8K: begin
                top3 = {SMALL_TOP, ba[0]};
            end
            HIOB_RAM_16K: begin
                top3 = {SMALL_TOP, ba[13]};
                cs1  = is_word | ~ba[0];
                cs2  = is_word | ba[0];
            end
            HIOB_RAM_32K: begin
                top3 = {ba[0], ba[14], ba[13]};
            end
            HIOB_RAM_64K: begin
                top3 = ba[15:13];
                cs1  = is_word | ~ba[0];
                cs2  = is_word | ba[0];
            end
        endcase
    end

    // Host read data selection
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (in_port) begin
            if (port_go) begin
                rd_mux = dma_station_address_window ? {dma_pbyte, dma_pbyte} : buf_rdata;
            end
        end else if (in_station_address_window) begin
            rd_mux = {8'h00, station_address_window_mem[{1'b0, ofs[2:0]}]};
        end else if (in_core) begin
            rd_mux = {8'h00, core_rdata};
        end else if (ofs == OFS_SLOT) begin
            rd_mux = {8'h00, 7'h00, slot_ff};
        end else if (ofs == OFS_HCMD) begin
            rd_mux = {8'h00, hcmd_ff};
        end else if (ofs == OFS_HCFG) begin
            rd_mux = {8'h00, hcfg_ff};
        end else if (ofs == OFS_CFGA) begin
            rd_mux = {8'h00, cfg_a_ff};
        end
    end

    // Cycle tracking for one register write, core write and DMA step per host I/O strobe
    always_comb begin
        if (io_any) begin
            nxt_cyc = HIOB_IO;
        end else if (use_mem) begin
            nxt_cyc = HIOB_MEM;
        end else begin
            nxt_cyc = HIOB_IDLE;
        end
    end
    wire         io_first = io_any & (cyc_ff != HIOB_IO);
    wire         reg_wr   = io_wr & io_first & ~in_core & ~in_port;
    wire         rst_rel  = rst_prev_ff & ~reset;

    // Reset length tracking that qualifies strap capture
    always_ff @(posedge core_clk) begin
        rst_prev_ff <= reset;
        if (reset) begin
            rst_cnt_ff  <= (rst_cnt_ff == 7'(RST_MIN)) ? rst_cnt_ff
                                                        : rst_cnt_ff + 7'd1;
            rst_long_ff <= rst_long_ff | (rst_cnt_ff == 7'(RST_MIN - 1));
        end else begin
            rst_cnt_ff  <= 7'd0;
            rst_long_ff <= 1'b0;
        end
    end

    // Configuration, hidden and control registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfg_a_ff <= CFG_A_RST;
            cfg_b_ff <= CFG_B_RST;
            cfg_c_ff <= CFG_C_RST;
            hcmd_ff  <= 8'h00;
            hcfg_ff  <= 8'h00;
            ctl1_ff  <= 8'h00;
            ctl2_ff  <= 8'h00;
            cyc_ff   <= HIOB_IDLE;
        end else begin
            cyc_ff <= nxt_cyc;
            if (rst_rel & rst_long_ff) begin
                cfg_a_ff <= cfg_pins.a;
                cfg_b_ff <= cfg_pins.b;
                cfg_c_ff <= cfg_pins.c;
            end else if (reg_wr) begin
                unique case (ofs)
                    OFS_HCMD: hcmd_ff <= host.wdata[7:0];
                    OFS_HCFG: hcfg_ff <= host.wdata[7:0];
                    OFS_CFGA: cfg_a_ff <= host.wdata[7:0];
                    OFS_SLOT: ctl1_ff <= host.wdata[7:0];
                    OFS_CTL2: ctl2_ff <= host.wdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // Slot width caught at reset release
    always_ff @(posedge core_clk) begin
        if (rst_rel) begin
            slot_ff <= slot_width_input;
        end
    end

    // Station address storage and read-back port
    always_ff @(posedge core_clk) begin
        if (station_address_window_load_we) begin
            station_address_window_mem[station_address_window_load_addr] <= station_address_window_load_data;
        end
        station_address_window_store_ff <= station_address_window_mem[station_address_window_store_addr];
    end

    // Host data and core port outputs
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_ff      <= 16'h0000;
            rdata_oe_ff   <= 1'b0;
            core_sel_ff   <= 1'b0;
            core_wr_ff    <= 1'b0;
            core_reg_ff   <= 4'h0;
            core_wdata_ff <= 8'h00;
            step_ff       <= 1'b0;
            base_ff       <= 10'h000;
            base_ok_ff    <= 1'b0;
        end else begin
            rdata_ff      <= mem_rd ? buf_rdata : rd_mux;
            rdata_oe_ff   <= io_rd | mem_rd;
            core_sel_ff   <= io_any & in_core;
            core_wr_ff    <= io_wr & in_core & io_first;
            core_reg_ff   <= ofs[3:0];
            core_wdata_ff <= host.wdata[7:0];
            step_ff       <= io_first & port_go;
            base_ff       <= base;
            base_ok_ff    <= base_ok;
        end
    end

    // Buffer SRAM drive
    always_ff @(posedge core_clk) begin
        if (reset) begin
            baddr_ff  <= 15'h0000;
            cs1_n_ff  <= 1'b1;
            cs2_n_ff  <= 1'b1;
            brd_n_ff  <= 1'b1;
            bwr_n_ff  <= 1'b1;
            bwdata_ff <= 16'h0000;
            bwoe_ff   <= 1'b0;
        end else begin
            baddr_ff  <= {top3, ba[12:1]};
            cs1_n_ff  <= ~(buf_go & cs1);
            cs2_n_ff  <= ~(buf_go & cs2);
            brd_n_ff  <= ~buf_rd;
            bwr_n_ff  <= ~buf_wr;
            bwdata_ff <= host.wdata;
            bwoe_ff   <= buf_wr;
        end
    end

    assign host_rdata            = rdata_ff;
    assign host_rdata_oe         = rdata_oe_ff;
    assign network_core_sel      = core_sel_ff;
    assign network_core_wr       = core_wr_ff;
    assign network_core_reg      = core_reg_ff;
    assign network_core_wdata    = core_wdata_ff;
    assign rdma_step             = step_ff;
    assign station_address_window_store_data       = station_address_window_store_ff;
    assign buffer_address        = baddr_ff;
    assign ram_chip_select_one_n = cs1_n_ff;
    assign ram_chip_select_two_n = cs2_n_ff;
    assign buf_rd_n              = brd_n_ff;
    assign buf_wr_n              = bwr_n_ff;
    assign buf_wdata             = bwdata_ff;
    assign buf_wdata_oe          = bwoe_ff;
    assign io_base               = base_ff;
    assign io_base_valid         = base_ok_ff;
    assign host_control_first    = ctl1_ff;
    assign host_control_second   = ctl2_ff;
    assign slot_width_status     = slot_ff;
endmodule : hiob_top

/* sim/hiob_top_properties.sv */
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
module hiob_top_properties
    import hiob_pkg::*;
(
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 reset,
    // Host and core side
    input wire hiob_pkg::hiob_host_t host,
    input wire logic                 host_rdata_oe,
    input wire logic                 network_core_wr,
    input wire logic [7:0]           network_core_wdata,
    input wire logic                 rdma_active,
    input wire logic                 rdma_step,
    // Buffer and status
    input wire logic [15:1]          buffer_address,
    input wire logic                 ram_chip_select_two_n,
    input wire logic                 buf_rd_n,
    input wire logic                 buf_wr_n,
    input wire logic [9:0]           io_base,
    input wire logic                 io_base_valid,
    input wire logic [7:0]           host_control_second,
    input wire logic                 slot_width_status
);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (reset);
    wire in_win = io_base_valid && host.io_addr[9:5] == io_base[9:5];
    wire rd_hit = in_win && !host.io_rd_n || host.mem_sel && !host.mem_rd_n;
    wire wr_hit = in_win && !host.io_wr_n;
    wire idle   = host.io_rd_n && host.io_wr_n && !host.mem_sel;

    a_base_aligned: assert property (
        io_base_valid |-> io_base[4:0] == 5'h00 && io_base[9])
        else $error("io base off its grid");
    a_oe_cause: assert property (
        host_rdata_oe == $past(rd_hit))
        else $error("read enable without a hit");
    a_core_wdata: assert property (
        network_core_wr |-> $past(wr_hit)
            && network_core_wdata == $past(host.wdata[7:0]))
        else $error("core write without cause");
    a_ctl2_cause: assert property (
        $changed(host_control_second) |-> $past(wr_hit)
            && $past(host.io_addr[4:0]) == OFS_CTL2)
        else $error("control two changed wrongly");
    a_step_cause: assert property (
        rdma_step |-> $past(rdma_active) && $past(in_win))
        else $error("step without active transfer");
    a_buf_idle: assert property (
        idle [*2] |-> buf_rd_n && buf_wr_n)
        else $error("buffer strobe while host idle");
    a_low_addr: assert property (
        (!buf_rd_n || !buf_wr_n) && $past(host.mem_sel)
            |-> buffer_address[12:1] == $past(host.mem_addr[12:1]))
        else $error("low buffer address wrong");
    a_even_byte: assert property (
        $past(host.mem_sel) && !$past(host.word)
            && !$past(host.mem_addr[0]) |-> ram_chip_select_two_n)
        else $error("odd select on even byte");
    a_slot_hold: assert property (
        !$past(reset) && !$past(reset, 2) |-> $stable(slot_width_status))
        else $error("slot status moved");
    cover property (network_core_wr);
    cover property (rdma_step);
    cover property (!ram_chip_select_two_n);
endmodule : hiob_top_properties

bind hiob_top hiob_top_properties hiob_top_properties_i (
    .core_clk, .reset, .host, .host_rdata_oe, .network_core_wr,
    .network_core_wdata, .rdma_active, .rdma_step, .buffer_address,
    .ram_chip_select_two_n, .buf_rd_n, .buf_wr_n, .io_base,
    .io_base_valid, .host_control_second, .slot_width_status
);

/* sim/hiob_far_model.sv */
// Network core and buffer SRAM model beside the decoder
`timescale 1ns/1ps
module hiob_far_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Core side
    input  wire logic        rdma_step,
    output logic [7:0]       core_rdata,
    output logic [15:0]      rdma_addr,
    // Buffer SRAM
    input  wire logic [15:1] buffer_address,
    input  wire logic        ram_chip_select_one_n,
    input  wire logic        ram_chip_select_two_n,
    input  wire logic        buf_rd_n,
    input  wire logic        buf_wr_n,
    input  wire logic [15:0] buf_wdata,
    output logic [15:0]      buf_rdata
);
    logic [15:0] mem [0:32767];
    logic [15:0] noise_ff;
    wire sel = !(ram_chip_select_one_n && ram_chip_select_two_n);
    assign core_rdata = 8'hc3;
    // Released bus wanders every cycle
    assign buf_rdata = (sel && !buf_rd_n) ? mem[buffer_address] : noise_ff;
    always_ff @(posedge core_clk) begin
        noise_ff <= reset ? 16'h5a5a : ~noise_ff + 16'h1;
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdma_addr <= 16'h4000;
        end else if (rdma_step) begin
            rdma_addr <= rdma_addr + 16'h2;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!buf_wr_n && !ram_chip_select_one_n) begin
            mem[buffer_address][7:0] <= buf_wdata[7:0];
        end
        if (!buf_wr_n && !ram_chip_select_two_n) begin
            mem[buffer_address][15:8] <= buf_wdata[15:8];
        end
    end
endmodule : hiob_far_model

/* sim/hiob_top_test.sv */
// Directed regression for the host decode block
`timescale 1ns/1ps
module hiob_top_test;
    import hiob_pkg::*;
    localparam logic [9:0] PLAIN [8] = '{10'h300, 10'h000, 10'h240,
        10'h280, 10'h2c0, 10'h320, 10'h340, 10'h360};
    localparam logic [9:0] BANK1 [8] = '{10'h380, 10'h3a0, 10'h3c0,
        10'h3e0, 10'h200, 10'h220, 10'h2a0, 10'h2e0};
    logic        core_clk, reset, slot, rdma_active, station_address_window_we, oe;
    logic [3:0]  station_address_window_addr, station_address_window_store_addr, network_core_reg;
    logic [7:0]  station_address_window_data, station_address_window_store_data, core_rdata;
    logic [7:0]  network_core_wdata, host_control_first;
    logic [9:0]  base, io_base;
    logic [15:0] rd, host_rdata, rdma_addr, buf_rdata, buf_wdata;
    logic [15:1] buffer_address;
    logic [16:0] got;
    logic        io_base_valid, rdma_step, cs1_n, cs2_n, buf_rd_n, buf_wr_n;
    hiob_cfg_t   cfg;
    hiob_host_t  host;
    int          fails, checks;

    hiob_top #(.RST_MIN(12)) hiob_top_i (
        .core_clk, .reset, .cfg_pins(cfg), .slot_width_input(slot), .host,
        .host_rdata, .host_rdata_oe(), .core_rdata, .network_core_sel(),
        .network_core_wr(), .network_core_reg, .network_core_wdata,
        .rdma_active, .rdma_addr, .rdma_step, .station_address_window_load_we(station_address_window_we),
        .station_address_window_load_addr(station_address_window_addr), .station_address_window_load_data(station_address_window_data),
        .station_address_window_store_addr, .station_address_window_store_data, .buf_rdata, .buffer_address,
        .ram_chip_select_one_n(cs1_n), .ram_chip_select_two_n(cs2_n),
        .buf_rd_n, .buf_wr_n, .buf_wdata, .buf_wdata_oe(), .io_base,
        .io_base_valid, .host_control_first, .host_control_second(),
        .slot_width_status());
    hiob_far_model hiob_far_model_i (
        .core_clk, .reset, .rdma_step, .core_rdata, .rdma_addr,
        .buffer_address, .ram_chip_select_one_n(cs1_n),
        .ram_chip_select_two_n(cs2_n), .buf_rd_n, .buf_wr_n, .buf_wdata,
        .buf_rdata);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk

    task automatic io(input logic wr, input logic [4:0] ofs,
                      input logic [7:0] wd);
        @(negedge core_clk);
        host.io_addr = base + {5'h00, ofs};
        host.wdata = {8'h00, wd};
        host.io_wr_n = !wr;
        host.io_rd_n = wr;
        @(negedge core_clk);
        rd = host_rdata;
        oe = hiob_top_i.host_rdata_oe;
        host.io_wr_n = 1'b1;
        host.io_rd_n = 1'b1;
        if (wr) @(negedge core_clk);
    endtask : io

    task automatic mem(input logic wr, input logic [15:0] a, input logic w);
        @(negedge core_clk);
        host.mem_addr = a;
        host.word = w;
        host.mem_sel = 1'b1;
        host.mem_wr_n = !wr;
        host.mem_rd_n = wr;
        @(negedge core_clk);
        got = {cs1_n, cs2_n, buffer_address};
        host.mem_sel = 1'b0;
        host.mem_wr_n = 1'b1;
        host.mem_rd_n = 1'b1;
    endtask : mem

    task automatic rst(input int n);
        @(negedge core_clk);
        reset = 1'b1;
        repeat (n) @(negedge core_clk);
        reset = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : rst

    // Expected selects and address for one host memory access
    function automatic logic [16:0] ea(input logic [15:0] o,
                                       input logic [1:0] sz, input logic w);
        logic [2:0] t;
        logic [1:0] cs;
        case (sz)
            2'd0: t = {2'b01, o[0]};
            2'd1: t = {2'b01, o[13]};
            2'd2: t = {o[0], o[14], o[13]};
            default: t = o[15:13];
        endcase
        cs = !sz[0] ? 2'b01 : w ? 2'b00 : o[0] ? 2'b10 : 2'b01;
        return {cs, t, o[12:1]};
    endfunction : ea

    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        conclude();
    end

    initial begin
        reset = 1'b1;
        host = '{default: '0, io_rd_n: 1'b1, io_wr_n: 1'b1,
                 mem_rd_n: 1'b1, mem_wr_n: 1'b1};
        cfg = '0;
        slot = 1'b1;
        {rdma_active, station_address_window_we, station_address_window_addr, station_address_window_data} = '0;
        station_address_window_store_addr = 4'h0;
        base = PLAIN[0];
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(io_base_valid, 1'b0);
        io(1'b0, OFS_SLOT, 8'h00);
        chk(oe, 1'b0);
        $display("test defaults done");

        rst(20);
        chk(io_base, PLAIN[0]);
        slot = 1'b0;
        io(1'b0, OFS_SLOT, 8'h00);
        chk({oe, rd[0]}, 2'b11);
        io(1'b0, OFS_HCMD, 8'h00);
        chk(rd[7:0], 8'h00);
        io(1'b0, OFS_HCFG, 8'h00);
        chk(rd[7:0], 8'h00);
        io(1'b1, OFS_SLOT, 8'h5a);
        chk(host_control_first, 8'h5a);
        io(1'b1, OFS_CTL2, 8'ha5);
        chk(hiob_top_i.host_control_second, 8'ha5);
        io(1'b0, OFS_SLOT, 8'h00);
        chk(rd[0], 1'b1);
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk);
            station_address_window_we = 1'b1;
            station_address_window_addr = 4'(i);
            station_address_window_data = 8'h10 + 8'(i);
        end
        @(negedge core_clk);
        station_address_window_we = 1'b0;
        for (int i = 0; i < 8; i++) begin
            io(1'b0, OFS_STATION_ADDRESS_WINDOW + 5'(i), 8'h00);
            chk(rd[7:0], 8'h10 + 8'(i));
        end
        station_address_window_store_addr = 4'h3;
        repeat (2) @(negedge core_clk);
        chk(station_address_window_store_data, 8'h13);
        for (int i = 0; i < 16; i++) begin
            io(1'b1, OFS_CORE + 5'(i), 8'(i) ^ 8'h5c);
            chk({network_core_reg, network_core_wdata}, {4'(i), 8'(i) ^ 8'h5c});
        end
        io(1'b0, 5'h1f, 8'h00);
        chk(rd[7:0], 8'hc3);
        $display("test window done");

        io(1'b1, OFS_HCMD, 8'h01);
        io(1'b1, OFS_HCFG, 8'h03);
        base = BANK1[0];
        chk(io_base, base);
        for (int c = 1; c < 8; c++) begin
            io(1'b1, OFS_CFGA, 8'(c));
            base = BANK1[c];
            chk({io_base_valid, io_base}, {1'b1, base});
        end
        io(1'b1, OFS_HCMD, 8'h00);
        base = PLAIN[7];
        chk(io_base, base);
        io(1'b1, OFS_HCMD, 8'h01);
        base = BANK1[7];
        chk(io_base, base);
        io(1'b1, OFS_HCFG, 8'h02);
        base = PLAIN[7];
        chk(io_base, base);
        for (int c = 7; c > 0; c--) begin
            io(1'b1, OFS_CFGA, 8'(c));
            base = PLAIN[c];
            chk(io_base_valid, c != 1);
            if (c != 1) chk(io_base, base);
        end
        io(1'b0, OFS_SLOT, 8'h00);
        chk(oe, 1'b0);
        $display("test bases done");

        for (int s = 0; s < 4; s++) begin
            cfg.c = 8'(s);
            rst(20);
            base = PLAIN[0];
            mem(1'b1, 16'h6ab5, 1'b0);
            chk(got, ea(16'h2ab5, 2'(s), 1'b0));
            mem(1'b0, 16'hc2b4, 1'b0);
            chk(got, ea(16'h02b4, 2'(s), 1'b0));
            mem(1'b0, 16'h2b32, 1'b1);
            chk(got, ea(16'h2b32, 2'(s), 1'b1));
        end
        cfg = '{a: 8'h00, b: 8'h02, c: 8'h03};
        rst(20);
        mem(1'b0, 16'hb6b5, 1'b0);
        chk(got, ea(16'hb6b5, 2'h3, 1'b0));
        $display("test memory done");

        cfg = '{a: 8'h00, b: 8'h01, c: 8'h00};
        rst(20);
        io(1'b0, OFS_DPORT, 8'h00);
        chk({rd, rdma_addr}, {16'h0000, 16'h4000});
        rdma_active = 1'b1;
        io(1'b0, OFS_DPORT, 8'h00);
        io(1'b0, OFS_DPORT + 5'h2, 8'h00);
        @(negedge core_clk);
        chk(rdma_addr, 16'h4004);
        io(1'b1, OFS_SLOT, 8'h77);
        chk({host_control_first, network_core_reg}, {8'h00, 4'h1});
        $display("test io port done");
        conclude();
    end
endmodule : hiob_top_test
